/* pkg/rcp_pkg.sv */
/*
 * Package for the receiver configuration and power-down register bank.
 * Holds register offsets, field positions, reset values and the control and status struct layouts.
 * Assumes a 32-bit Avalon-MM slave with byte addressing on the system clock.
 */
// Summary of operation
// - In master mode, keep-clocks bit 7 keeps bit and frame clocks after source loss.
// - Three-bit selector picks interrupt, channel status one to five, or link status readback.
// - Continuous read-back bit turns continuous read-back mode on at 1, off at 0.
// - Bit 4 enables audio streaming with status flags appended; default off.
// - Bit 5 turns receiver inputs four to seven into general outputs.
// - Bit 6 at 0 truncates received words by length; at 1 passes them whole.
// - High-rate bit selects 192 kHz maximum at 1, default, or 96 kHz at 0.
// - PLL power-down: 0 keeps the PLL running, 1 powers it down.
// - Receiver power-down at 1 disables the receiver.
// - Transmitter power-down at 1 powers the transmitter down, at 0 runs it.
// - Clocks-after-loss applies only in master mode, where bit and frame clocks are outputs.
package rcp_pkg;
    localparam logic [7:0] RCP_AIFRX_OFFSET = 8'h70;
    localparam logic [7:0] RCP_RXCFG_OFFSET = 8'h74;
    localparam logic [7:0] RCP_POWER_DOWN_CONTROL_OFFSET = 8'h78;
    localparam logic [7:0] RCP_STAT_OFFSET = 8'h7C;
    localparam logic [7:0] RCP_AIFRX_INDEX = 8'h1C;
    localparam logic [7:0] RCP_RXCFG_INDEX = 8'h1D;
    localparam logic [7:0] RCP_POWER_DOWN_CONTROL_INDEX = 8'h1E;

    localparam int RCP_AUDIO_INTERFACE_MASTER_SELECT_BIT = 6;
    localparam int RCP_KEEP_CLK_BIT = 7;
    localparam int RCP_CONTINUOUS_READBACK_ENABLE_BIT = 3;
    localparam int RCP_FLAGS_BIT = 4;
    localparam int RCP_GPO_BIT = 5;
    localparam int RCP_TRUNC_BIT = 6;
    localparam int RCP_HIRATE_BIT = 7;
    localparam int RCP_PLLPD_BIT = 0;
    localparam int RCP_RXPD_BIT = 1;
    localparam int RCP_TXPD_BIT = 2;

    localparam logic [7:0] RCP_AIFRX_RESET = 8'h06;
    localparam logic [7:0] RCP_RXCFG_RESET = 8'h80;
    localparam logic [7:0] RCP_POWER_DOWN_CONTROL_RESET = 8'h07;
    localparam logic [7:0] RCP_POWER_DOWN_CONTROL_MASK = 8'h07;

    localparam logic [2:0] RCP_SEL_INT = 3'h0;
    localparam logic [2:0] RCP_SEL_CS1 = 3'h1;
    localparam logic [2:0] RCP_SEL_CS5 = 3'h5;
    localparam logic [2:0] RCP_SEL_LINK = 3'h6;

    typedef struct packed {
        logic keep_clocks;
        logic audio_interface_master_select;
        logic continuous_readback_enable;
        logic flags_appended_mode;
        logic rx_inputs_as_outputs;
        logic truncation_mask;
        logic high_rate_support_enable;
        logic pll_power_down;
        logic receiver_power_down;
        logic transmitter_power_down;
        logic [2:0] readback_status_select;
    } rcp_ctrl_type;

    typedef struct packed {
        logic [7:0] int_status;
        logic [39:0] chan_status;
        logic [7:0] link_status;
    } rcp_status_type;
endpackage

/* rtl/rcp_readback_mux.sv */
/*
 * Status read-back selector.
 * Assumes status bytes are stable on the system clock.
 */
`timescale 1ns/1ns
module rcp_readback_mux (
    input wire logic [2:0] i_sel,
    input wire rcp_pkg::rcp_status_type i_status,
    output logic [7:0] o_byte
);
    always_comb begin
        o_byte = 8'h00;
        case (i_sel)
            rcp_pkg::RCP_SEL_INT: begin
                o_byte = i_status.int_status;
            end
            rcp_pkg::RCP_SEL_LINK: begin
                o_byte = i_status.link_status;
            end
            default: begin
                if (i_sel >= rcp_pkg::RCP_SEL_CS1 && i_sel <= rcp_pkg::RCP_SEL_CS5) begin
                    o_byte = i_status.chan_status[8 * (i_sel - rcp_pkg::RCP_SEL_CS1) +: 8];
                end
            end
        endcase
    end
endmodule // rcp_readback_mux

/* rtl/rcp_regs.sv */
/*
 * Receiver configuration and power-down register bank with Avalon-MM slave.
 * Assumes status inputs come from logic on i_mclk; the source-lost level is
 * a pin and is synchronised here.
 */
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
module rcp_regs (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    input wire rcp_pkg::rcp_status_type i_status,
    input wire logic i_source_lost,
    input wire logic i_clk_gen_active,
    output logic o_aif_clk_enable,
    output logic o_aif_clk_drive,
    output rcp_pkg::rcp_ctrl_type o_ctrl
);
    typedef enum logic [1:0] {
        RCP_IDLE = 2'b00,
        RCP_ACK = 2'b01
    } rcp_bus_state_type;

    logic [7:0] aifrx_q, aifrx_d;
    logic [7:0] rxcfg_q, rxcfg_d;
    logic [7:0] power_down_control_q, power_down_control_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    rcp_bus_state_type state_q, state_d;
    logic lost_meta_q, lost_sync_q;
    logic [7:0] status_byte;
    logic hit;

    rcp_readback_mux u_mux (
        .i_sel(rxcfg_q[2:0]),
        .i_status(i_status),
        .o_byte(status_byte)
    );

    always_comb begin
        hit = (i_avs_address == rcp_pkg::RCP_AIFRX_OFFSET)
            || (i_avs_address == rcp_pkg::RCP_RXCFG_OFFSET)
            || (i_avs_address == rcp_pkg::RCP_POWER_DOWN_CONTROL_OFFSET)
            || (i_avs_address == rcp_pkg::RCP_STAT_OFFSET);
    end

    always_comb begin
        aifrx_d = aifrx_q;
        rxcfg_d = rxcfg_q;
        power_down_control_d = power_down_control_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        state_d = state_q;
        case (state_q)
            RCP_IDLE: begin
                if (i_avs_write) begin
                    state_d = RCP_ACK;
                    resp_d = hit ? 2'h0 : 2'h3;
                    rdata_d = 32'h0000_0000;
                    if (i_avs_byteenable[0]) begin
                        case (i_avs_address)
                            rcp_pkg::RCP_AIFRX_OFFSET: aifrx_d = i_avs_writedata[7:0];
                            rcp_pkg::RCP_RXCFG_OFFSET: rxcfg_d = i_avs_writedata[7:0];
                            rcp_pkg::RCP_POWER_DOWN_CONTROL_OFFSET: begin
                                power_down_control_d = i_avs_writedata[7:0] & rcp_pkg::RCP_POWER_DOWN_CONTROL_MASK;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (i_avs_read) begin
                    state_d = RCP_ACK;
                    resp_d = hit ? 2'h0 : 2'h3;
                    case (i_avs_address)
                        rcp_pkg::RCP_AIFRX_OFFSET: rdata_d = {24'h000000, aifrx_q};
                        rcp_pkg::RCP_RXCFG_OFFSET: rdata_d = {24'h000000, rxcfg_q};
                        rcp_pkg::RCP_POWER_DOWN_CONTROL_OFFSET: rdata_d = {24'h000000, power_down_control_q};
                        rcp_pkg::RCP_STAT_OFFSET: rdata_d = {24'h000000, status_byte};
                        default: rdata_d = 32'h0000_0000;
                    endcase
                end
            end
            RCP_ACK: begin
                state_d = RCP_IDLE;
            end
            default: begin
                state_d = RCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            aifrx_q <= rcp_pkg::RCP_AIFRX_RESET;
            rxcfg_q <= rcp_pkg::RCP_RXCFG_RESET;
            power_down_control_q <= rcp_pkg::RCP_POWER_DOWN_CONTROL_RESET;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
            state_q <= RCP_IDLE;
        end else begin
            aifrx_q <= aifrx_d;
            rxcfg_q <= rxcfg_d;
            power_down_control_q <= power_down_control_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lost_meta_q <= 1'b0;
            lost_sync_q <= 1'b0;
        end else begin
            lost_meta_q <= i_source_lost;
            lost_sync_q <= lost_meta_q;
        end
    end

    // Waitrequest drops in the cycle the answer is registered.
    assign o_avs_waitrequest = (state_q != RCP_ACK);
    assign o_avs_readdata = rdata_q;
    assign o_avs_response = resp_q;

    always_comb begin
        o_ctrl.audio_interface_master_select = aifrx_q[rcp_pkg::RCP_AUDIO_INTERFACE_MASTER_SELECT_BIT];
        o_ctrl.keep_clocks = aifrx_q[rcp_pkg::RCP_KEEP_CLK_BIT];
        o_ctrl.readback_status_select = rxcfg_q[2:0];
        o_ctrl.continuous_readback_enable = rxcfg_q[rcp_pkg::RCP_CONTINUOUS_READBACK_ENABLE_BIT];
        o_ctrl.flags_appended_mode = rxcfg_q[rcp_pkg::RCP_FLAGS_BIT];
        o_ctrl.rx_inputs_as_outputs = rxcfg_q[rcp_pkg::RCP_GPO_BIT];
        o_ctrl.truncation_mask = rxcfg_q[rcp_pkg::RCP_TRUNC_BIT];
        o_ctrl.high_rate_support_enable = rxcfg_q[rcp_pkg::RCP_HIRATE_BIT];
        o_ctrl.pll_power_down = power_down_control_q[rcp_pkg::RCP_PLLPD_BIT];
        o_ctrl.receiver_power_down = power_down_control_q[rcp_pkg::RCP_RXPD_BIT];
        o_ctrl.transmitter_power_down = power_down_control_q[rcp_pkg::RCP_TXPD_BIT];
    end

    // Clock pins are driven only in master mode; after loss only if kept.
    assign o_aif_clk_drive = aifrx_q[rcp_pkg::RCP_AUDIO_INTERFACE_MASTER_SELECT_BIT];
    assign o_aif_clk_enable = aifrx_q[rcp_pkg::RCP_AUDIO_INTERFACE_MASTER_SELECT_BIT] && i_clk_gen_active
        && (!lost_sync_q || aifrx_q[rcp_pkg::RCP_KEEP_CLK_BIT]);
endmodule // rcp_regs

/* verification/rcp_regs_props.sv */
/* Checker for rcp_regs: field writes, hold, status read-back and clock gating.
   Bound to every rcp_regs instance; one clock domain. */
`timescale 1ns/1ns
module rcp_regs_chk (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire rcp_pkg::rcp_status_type i_status,
    input wire logic i_source_lost,
    input wire logic i_clk_gen_active,
    input wire logic o_aif_clk_enable,
    input wire logic o_aif_clk_drive,
    input wire rcp_pkg::rcp_ctrl_type o_ctrl
);
    logic wr;
    logic rs;
    assign wr = i_avs_write && o_avs_waitrequest && i_avs_byteenable[0];
    assign rs = i_avs_read && o_avs_waitrequest && i_avs_address == 8'h7C;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_cfg; wr && i_avs_address == 8'h74 |=> {o_ctrl.high_rate_support_enable,
        o_ctrl.truncation_mask, o_ctrl.rx_inputs_as_outputs, o_ctrl.flags_appended_mode,
        o_ctrl.continuous_readback_enable, o_ctrl.readback_status_select}
        == $past(i_avs_writedata[7:0]); endproperty
    a_cfg: assert property (p_cfg) else $error("config write lost");
    property p_pwr; wr && i_avs_address == 8'h78 |=> {o_ctrl.transmitter_power_down,
        o_ctrl.receiver_power_down, o_ctrl.pll_power_down} == $past(i_avs_writedata[2:0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power write lost");
    property p_hold; !wr |=> $stable(o_ctrl); endproperty
    a_hold: assert property (p_hold) else $error("field changed unwritten");
    property p_keep; (o_ctrl.keep_clocks && o_aif_clk_drive && i_clk_gen_active)[*2]
        |-> o_aif_clk_enable; endproperty
    a_keep: assert property (p_keep) else $error("clocks stopped");
    property p_stop; (i_source_lost && !o_ctrl.keep_clocks)[*4] |-> !o_aif_clk_enable;
    endproperty
    a_stop: assert property (p_stop) else $error("clocks kept after loss");
    property p_ms; o_aif_clk_enable |-> o_aif_clk_drive; endproperty
    a_ms: assert property (p_ms) else $error("clock out in slave mode");
    property p_drv; o_ctrl.audio_interface_master_select |-> o_aif_clk_drive; endproperty
    a_drv: assert property (p_drv) else $error("master pins not driven");
    property p_int; rs && o_ctrl.readback_status_select == 3'h0
        |=> o_avs_readdata[7:0] == $past(i_status.int_status); endproperty
    a_int: assert property (p_int) else $error("wrong status read");
    property p_lnk; rs && o_ctrl.readback_status_select == 3'h6
        |=> o_avs_readdata[7:0] == $past(i_status.link_status); endproperty
    a_lnk: assert property (p_lnk) else $error("wrong link read");
    property p_upr; !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000; endproperty
    a_upr: assert property (p_upr) else $error("upper read bits set");
endmodule // rcp_regs_chk
bind rcp_regs rcp_regs_chk rcp_regs_chk_i (.i_mclk, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_status, .i_source_lost, .i_clk_gen_active, .o_aif_clk_enable, .o_aif_clk_drive, .o_ctrl);

/* verification/tb_top.sv */
/* Testbench for rcp_regs: register rows, status read-back, clock gating, reset.
   Drives every design input itself, registers over Avalon-MM and source loss directly; no partner model. */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb_top;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [1:0] o_avs_response;
    rcp_pkg::rcp_status_type i_status = {8'h11, 40'h2524232221, 8'h66};
    logic i_source_lost = 1'b0;
    logic i_clk_gen_active = 1'b1;
    logic o_aif_clk_enable;
    logic o_aif_clk_drive;
    rcp_pkg::rcp_ctrl_type o_ctrl;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] rd;
    logic [1:0] rsp;
    logic [23:0] rows [9] = '{24'h74FFFF, 24'h740000, 24'h74A5A5, 24'h745A5A, 24'h780000,
        24'h78FF07, 24'h780505, 24'h70CACA, 24'h703535};
    logic [7:0] st [8] = '{8'h11, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h66, 8'h00};
    rcp_regs rcp_regs_i (.i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .o_avs_response, .i_status, .i_source_lost, .i_clk_gen_active, .o_aif_clk_enable,
        .o_aif_clk_drive, .o_ctrl);
    always #4 i_mclk = ~i_mclk;
    task automatic final_report;
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        rd = o_avs_readdata[7:0];
        rsp = o_avs_response;
        if (n >= 50) errors++;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        bus(0, 8'h70, 8'h00); `CHK(rd, 8'h06)
        `CHK(o_ctrl.keep_clocks, 1'b0)
        bus(0, 8'h74, 8'h00); `CHK(rd, 8'h80)
        bus(0, 8'h78, 8'h00); `CHK(rd, 8'h07)
        foreach (rows[i]) begin
            bus(1, rows[i][23:16], rows[i][15:8]);
            bus(0, rows[i][23:16], 8'h00);
            `CHK(rd, rows[i][7:0])
            `CHK(rsp, 2'h0)
        end
        for (int s = 0; s < 8; s++) begin
            bus(1, 8'h74, 8'h80 | 8'(s));
            bus(0, 8'h7C, 8'h00); `CHK(rd, st[s])
        end
        bus(1, 8'h40, 8'hFF); `CHK(rsp, 2'h3)
        i_avs_byteenable <= 4'hE;
        bus(1, 8'h74, 8'h00);
        i_avs_byteenable <= 4'hF;
        bus(0, 8'h74, 8'h00); `CHK(rd, 8'h87)
        bus(1, 8'h70, 8'h4A); repeat (3) @(posedge i_mclk);
        `CHK({o_aif_clk_enable, o_aif_clk_drive}, 2'h3)
        i_source_lost <= 1'b1; repeat (6) @(posedge i_mclk);
        `CHK(o_aif_clk_enable, 1'b0)
        bus(1, 8'h70, 8'hCA); repeat (3) @(posedge i_mclk);
        `CHK(o_aif_clk_enable, 1'b1)
        bus(1, 8'h70, 8'h8A); repeat (3) @(posedge i_mclk);
        `CHK({o_aif_clk_enable, o_aif_clk_drive}, 2'h0)
        i_rst <= 1'b1; @(posedge i_mclk); i_rst <= 1'b0;
        bus(0, 8'h74, 8'h00); `CHK(rd, 8'h80)
        final_report;
    end
endmodule // tb_top
